// >>> shared/ppcc_pkg.sv
// Constants shared by the port pin configuration logic: register map, field positions,
// reset values and the start-up delay count.
// Assumes a byte-wide data memory space with an 8-bit address.
`default_nettype none

package ppcc_pkg;

  // ==========================================================================
  // Port indices and register map
  localparam int NUM_PORTS = 5;
  localparam int PORT_C = 0;
  localparam int PORT_F = 1;
  localparam int PORT_G = 2;
  localparam int PORT_J = 3;
  localparam int PORT_L = 4;
  // Each port takes four byte addresses: data, configuration, pin input, one unused.
  localparam logic [7:0] PORT_BASE [NUM_PORTS] = '{8'hd8, 8'hd4, 8'hd0, 8'hdc, 8'he0};
  localparam logic [1:0] OFS_DATA = 2'h0;
  localparam logic [1:0] OFS_CFG = 2'h1;
  localparam logic [1:0] OFS_PIN = 2'h2;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] J_CFG_RESET = 8'hff;
  localparam logic [7:0] J_DATA_RESET = 8'hff;

  // ==========================================================================
  // Port G special bits and alternate pins
  localparam int G_HALT_BIT = 7;
  localparam int G_IDLE_BIT = 6;
  localparam int G_DELAY_BIT = 7;
  localparam int G_ALT_PHASE_BIT = 6;
  localparam int G_OSC_PIN = 7;
  localparam int G_SI_PIN = 6;
  localparam int G_SK_PIN = 5;
  localparam int G_SO_PIN = 4;
  localparam int G_TIO_PIN = 3;
  localparam int G_TCAP_PIN = 2;
  localparam int G_WDOG_PIN = 1;
  localparam int G_INT_PIN = 0;
  localparam logic [7:0] G_SPECIAL_READ_MASK = 8'h3f;

  // ==========================================================================
  // Port L two-wire bus pins and low-voltage input pins
  localparam int L_SDA_PIN = 0;
  localparam int L_SCL_PIN = 1;

  // ==========================================================================
  // Timing
  localparam logic [7:0] HALT_EXIT_DELAY_CYCLES = 8'h20;

endpackage : ppcc_pkg

`default_nettype wire

// >>> shared/ppcc_port_if.sv
// Carrier between the port control logic and one 8-bit pad group.
// Assumes both ends run on the core clock.
`default_nettype none

interface ppcc_port_if;
  logic [7:0] cfg;
  logic [7:0] dat;
  logic [7:0] pad_in;
  logic [7:0] pad_out;
  logic [7:0] pad_oe_n;
  logic [7:0] pull_en;
  logic [7:0] pin_val;

  modport ctrl (output cfg, output dat, output pad_in,
                input pad_out, input pad_oe_n, input pull_en, input pin_val);
  modport pads (input cfg, input dat, input pad_in,
                output pad_out, output pad_oe_n, output pull_en, output pin_val);
endinterface : ppcc_port_if

`default_nettype wire

// >>> design/ppcc_port_pads.sv
// One 8-bit pad group: turns configuration and data bits into pad drive and pull-up,
// and samples the pad levels.
// Assumes pad inputs are synchronous to the core clock.
`default_nettype none

module ppcc_port_pads (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pad group
  ppcc_port_if.pads bus
);

  // ==========================================================================
  // Pad drive
  assign bus.pad_out = bus.dat;
  assign bus.pad_oe_n = ~bus.cfg;
  assign bus.pull_en = ~bus.cfg & bus.dat;

  // ==========================================================================
  // Pin sampling
  always_ff @(posedge clk) begin
    if (rst) begin
      bus.pin_val <= 8'h00;
    end else begin
      bus.pin_val <= bus.pad_in;
    end
  end

endmodule : ppcc_port_pads

`default_nettype wire

// >>> design/ppcc_power_ctl.sv
// Low-power mode sequencing: HALT entry and exit with optional start-up delay, IDLE.
// Assumes the core clock keeps running so the exit can be sequenced here.
`default_nettype none

module ppcc_power_ctl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests and wake sources
  input wire logic halt_req,
  input wire logic idle_req,
  input wire logic wake_event,
  input wire logic idle_exit,
  input wire logic delay_en,
  // Mode status
  output logic halt_mode,
  output logic idle_mode,
  output logic delay_active
);

  typedef enum logic [1:0] {RUN, HALTED, CLK_DELAY} ppcc_power_state_type;

  ppcc_power_state_type state_q;
  logic [7:0] delay_cnt_q;

  // ==========================================================================
  // HALT sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= RUN;
      delay_cnt_q <= 8'h00;
    end else begin
      unique case (state_q)
        RUN: begin
          if (halt_req) begin
            state_q <= HALTED;
          end
        end
        HALTED: begin
          if (wake_event && delay_en) begin
            state_q <= CLK_DELAY;
            delay_cnt_q <= ppcc_pkg::HALT_EXIT_DELAY_CYCLES - 8'h01;
          end else if (wake_event) begin
            state_q <= RUN;
          end
        end
        CLK_DELAY: begin
          if (delay_cnt_q == 8'h00) begin
            state_q <= RUN;
          end else begin
            delay_cnt_q <= delay_cnt_q - 8'h01;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // IDLE flag; a new request wins over a simultaneous exit.
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_mode <= 1'b0;
    end else if (idle_req) begin
      idle_mode <= 1'b1;
    end else if (idle_exit || wake_event) begin
      idle_mode <= 1'b0;
    end
  end

  assign halt_mode = (state_q != RUN);
  assign delay_active = (state_q == CLK_DELAY);

endmodule : ppcc_power_ctl

`default_nettype wire

// >>> design/ppcc_port_top.sv
// Port pin configuration and control for five 8-bit ports (C, F, G, J, L), with the
// Port G special bits, the Port L two-wire and low-voltage roles and wake-up levels.
// Assumes a byte-wide data memory access port and pads synchronous to the core clock.
//
// Functional notes
// - Config and data bits pick pin setup.
// - Each port: config, data, pin registers.
// - Port G data bit 7 enters HALT.
// - Port G data bit 6 enters IDLE.
// - Port G config bit 6: alternate clock phase.
// - G7 config bit adds delay with RC.
// - Port G data bits 6, 7 read zero.
// - Watchdog option overrides Port G pin 1.
// - Crystal option: G7 drives oscillator output.
// - Otherwise G7 input; rising edge wakes HALT.
// - G6 is always a plain input.
// - Port J outputs driven high from reset.
// - L0-L2 low-voltage inputs need option and bus.
// - C, L wake levels; L0 SDA, L1 SCL.
// - Port G pins carry peripheral alternate functions.
// - Watchdog option bit 2 zero enables it.
`default_nettype none

module ppcc_port_top (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Data memory access
  input wire logic [7:0] MEM_ADDR,
  input wire logic MEM_WR,
  input wire logic MEM_RD,
  input wire logic [7:0] MEM_WDATA,
  output logic [7:0] MEM_RDATA,
  output logic MEM_RD_HIT,
  // Device options
  input wire logic OPT_WATCHDOG_DISABLE,
  input wire logic LOW_VOLTAGE_INPUT_SELECT,
  input wire logic OSC_CRYSTAL_SEL,
  input wire logic OSC_RC_SEL,
  // Port C pads
  input wire logic [7:0] PORT_C_IN,
  output logic [7:0] PORT_C_OUT,
  output logic [7:0] PORT_C_OE_N,
  output logic [7:0] PORT_C_PULLUP,
  // Port F pads
  input wire logic [7:0] PORT_F_IN,
  output logic [7:0] PORT_F_OUT,
  output logic [7:0] PORT_F_OE_N,
  output logic [7:0] PORT_F_PULLUP,
  // Port G pads
  input wire logic [7:0] PORT_G_IN,
  output logic [7:0] PORT_G_OUT,
  output logic [7:0] PORT_G_OE_N,
  output logic [7:0] PORT_G_PULLUP,
  // Port J pads
  input wire logic [7:0] PORT_J_IN,
  output logic [7:0] PORT_J_OUT,
  output logic [7:0] PORT_J_OE_N,
  output logic [7:0] PORT_J_PULLUP,
  // Port L pads
  input wire logic [7:0] PORT_L_IN,
  output logic [7:0] PORT_L_OUT,
  output logic [7:0] PORT_L_OE_N,
  output logic [7:0] PORT_L_PULLUP,
  // Port G peripheral sources
  input wire logic OSCILLATOR_CLOCK_OUT,
  input wire logic SUPERVISOR_FAULT_OUTPUT,
  input wire logic SERIAL_SHIFT_CLOCK_OE,
  input wire logic SERIAL_SHIFT_CLOCK_OUT,
  input wire logic SERIAL_DATA_OE,
  input wire logic SERIAL_DATA_OUT,
  input wire logic TIMER_IO_PIN_OE,
  input wire logic TIMER_IO_PIN_OUT,
  // Port G peripheral sinks
  output logic SERIAL_DATA_IN,
  output logic SERIAL_SHIFT_CLOCK_IN,
  output logic SERIAL_SHIFT_CLOCK_ALT_PHASE,
  output logic TIMER_IO_PIN_IN,
  output logic TIMER_CAPTURE_PIN,
  output logic EXTERNAL_INTERRUPT_INPUT,
  // Two-wire bus on Port L
  input wire logic TWB_ENABLE,
  input wire logic TWB_SDA_DRIVE_LOW,
  input wire logic TWB_SCL_DRIVE_LOW,
  output logic TWB_SDA_IN,
  output logic TWB_SCL_IN,
  output logic [2:0] L_LOW_VOLTAGE_ACTIVE,
  // Wake-up
  output logic [7:0] PORT_C_WAKE_LEVELS,
  output logic [7:0] PORT_L_WAKE_LEVELS,
  input wire logic WAKE_EVENT,
  input wire logic IDLE_EXIT,
  // Power modes
  output logic HALT_MODE,
  output logic IDLE_MODE,
  output logic HALT_EXIT_STARTUP_DELAY
);

  localparam int NP = ppcc_pkg::NUM_PORTS;
  localparam int PG = ppcc_pkg::PORT_G;
  localparam int PL = ppcc_pkg::PORT_L;

  logic [7:0] cfg_q [NP];
  logic [7:0] dat_q [NP];
  logic [7:0] eff_cfg [NP];
  logic [7:0] eff_dat [NP];
  logic [7:0] pad_in [NP];
  logic [7:0] pad_out [NP];
  logic [7:0] pad_oe_n [NP];
  logic [7:0] pull_en [NP];
  logic [7:0] pin_val [NP];
  logic [NP-1:0] port_hit;
  logic [1:0] reg_ofs;
  logic [7:0] rd_d;
  logic rd_hit_d;
  logic halt_wr;
  logic idle_wr;
  logic g7_prev_q;
  logic g7_rise;
  logic rc_clock;
  logic wake_any;

  // ==========================================================================
  // Address decode
  assign reg_ofs = MEM_ADDR[1:0];

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      port_hit[i] = (MEM_ADDR[7:2] == ppcc_pkg::PORT_BASE[i][7:2]) &&
                    (reg_ofs != 2'h3);
    end
  end

  // ==========================================================================
  // Configuration and data registers; Port J comes out of reset driving high.
  always_ff @(posedge CORE_CLK) begin
    for (int i = 0; i < NP; i++) begin
      if (RESET) begin
        cfg_q[i] <= (i == ppcc_pkg::PORT_J) ? ppcc_pkg::J_CFG_RESET
                                            : ppcc_pkg::CFG_RESET;
      end else if (MEM_WR && port_hit[i] && reg_ofs == ppcc_pkg::OFS_CFG) begin
        cfg_q[i] <= MEM_WDATA;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    for (int i = 0; i < NP; i++) begin
      if (RESET) begin
        dat_q[i] <= (i == ppcc_pkg::PORT_J) ? ppcc_pkg::J_DATA_RESET
                                            : ppcc_pkg::DATA_RESET;
      end else if (MEM_WR && port_hit[i] && reg_ofs == ppcc_pkg::OFS_DATA) begin
        dat_q[i] <= MEM_WDATA;
      end
    end
  end

  // ==========================================================================
  // Read port. The answer is registered and appears on the edge after MEM_RD.
  always_comb begin
    rd_d = 8'h00;
    rd_hit_d = 1'b0;
    for (int i = 0; i < NP; i++) begin
      if (port_hit[i]) begin
        rd_hit_d = 1'b1;
        unique case (reg_ofs)
          ppcc_pkg::OFS_DATA: begin
            rd_d = (i == ppcc_pkg::PORT_G) ? (dat_q[i] & ppcc_pkg::G_SPECIAL_READ_MASK)
                                           : dat_q[i];
          end
          ppcc_pkg::OFS_CFG: begin
            rd_d = cfg_q[i];
          end
          default: begin
            rd_d = pin_val[i];
          end
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      MEM_RDATA <= 8'h00;
      MEM_RD_HIT <= 1'b0;
    end else if (MEM_RD) begin
      MEM_RDATA <= rd_d;
      MEM_RD_HIT <= rd_hit_d;
    end else begin
      MEM_RD_HIT <= 1'b0;
    end
  end

  // ==========================================================================
  // Effective pin setup: software bits, then the fixed and peripheral overrides.
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      eff_cfg[i] = cfg_q[i];
      eff_dat[i] = dat_q[i];
    end
    eff_cfg[PG][ppcc_pkg::G_SI_PIN] = 1'b0;
    eff_dat[PG][ppcc_pkg::G_SI_PIN] = 1'b0;
    if (OSC_CRYSTAL_SEL) begin
      eff_cfg[PG][ppcc_pkg::G_OSC_PIN] = 1'b1;
      eff_dat[PG][ppcc_pkg::G_OSC_PIN] = OSCILLATOR_CLOCK_OUT;
    end else begin
      eff_cfg[PG][ppcc_pkg::G_OSC_PIN] = 1'b0;
      eff_dat[PG][ppcc_pkg::G_OSC_PIN] = 1'b0;
    end
    // The watchdog pin drives low when quiet and pulls high on a fault.
    if (!OPT_WATCHDOG_DISABLE) begin
      eff_cfg[PG][ppcc_pkg::G_WDOG_PIN] = ~SUPERVISOR_FAULT_OUTPUT;
      eff_dat[PG][ppcc_pkg::G_WDOG_PIN] = SUPERVISOR_FAULT_OUTPUT;
    end
    // Peripherals take over the level; software keeps the direction.
    if (SERIAL_SHIFT_CLOCK_OE) begin
      eff_dat[PG][ppcc_pkg::G_SK_PIN] = SERIAL_SHIFT_CLOCK_OUT;
    end
    if (SERIAL_DATA_OE) begin
      eff_dat[PG][ppcc_pkg::G_SO_PIN] = SERIAL_DATA_OUT;
    end
    if (TIMER_IO_PIN_OE) begin
      eff_dat[PG][ppcc_pkg::G_TIO_PIN] = TIMER_IO_PIN_OUT;
    end
    // Two-wire bus lines are open drain: drive low or float.
    if (TWB_ENABLE) begin
      eff_cfg[PL][ppcc_pkg::L_SDA_PIN] = TWB_SDA_DRIVE_LOW;
      eff_dat[PL][ppcc_pkg::L_SDA_PIN] = 1'b0;
      eff_cfg[PL][ppcc_pkg::L_SCL_PIN] = TWB_SCL_DRIVE_LOW;
      eff_dat[PL][ppcc_pkg::L_SCL_PIN] = 1'b0;
    end
  end

  // ==========================================================================
  // Pad groups
  assign pad_in[ppcc_pkg::PORT_C] = PORT_C_IN;
  assign pad_in[ppcc_pkg::PORT_F] = PORT_F_IN;
  assign pad_in[ppcc_pkg::PORT_G] = PORT_G_IN;
  assign pad_in[ppcc_pkg::PORT_J] = PORT_J_IN;
  assign pad_in[ppcc_pkg::PORT_L] = PORT_L_IN;

  ppcc_port_if port_bus [NP] ();

  for (genvar g = 0; g < NP; g++) begin : g_port
    assign port_bus[g].cfg = eff_cfg[g];
    assign port_bus[g].dat = eff_dat[g];
    assign port_bus[g].pad_in = pad_in[g];
    assign pad_out[g] = port_bus[g].pad_out;
    assign pad_oe_n[g] = port_bus[g].pad_oe_n;
    assign pull_en[g] = port_bus[g].pull_en;
    assign pin_val[g] = port_bus[g].pin_val;

    ppcc_port_pads u_pads (
      .clk(CORE_CLK),
      .rst(RESET),
      .bus(port_bus[g])
    );
  end

  assign PORT_C_OUT = pad_out[ppcc_pkg::PORT_C];
  assign PORT_C_OE_N = pad_oe_n[ppcc_pkg::PORT_C];
  assign PORT_C_PULLUP = pull_en[ppcc_pkg::PORT_C];
  assign PORT_F_OUT = pad_out[ppcc_pkg::PORT_F];
  assign PORT_F_OE_N = pad_oe_n[ppcc_pkg::PORT_F];
  assign PORT_F_PULLUP = pull_en[ppcc_pkg::PORT_F];
  assign PORT_G_OUT = pad_out[PG];
  assign PORT_G_OE_N = pad_oe_n[PG];
  assign PORT_G_PULLUP = pull_en[PG];
  assign PORT_J_OUT = pad_out[ppcc_pkg::PORT_J];
  assign PORT_J_OE_N = pad_oe_n[ppcc_pkg::PORT_J];
  assign PORT_J_PULLUP = pull_en[ppcc_pkg::PORT_J];
  assign PORT_L_OUT = pad_out[PL];
  assign PORT_L_OE_N = pad_oe_n[PL];
  assign PORT_L_PULLUP = pull_en[PL];

  // ==========================================================================
  // Peripheral inputs and wake-up levels
  assign SERIAL_DATA_IN = pin_val[PG][ppcc_pkg::G_SI_PIN];
  assign SERIAL_SHIFT_CLOCK_IN = pin_val[PG][ppcc_pkg::G_SK_PIN];
  assign TIMER_IO_PIN_IN = pin_val[PG][ppcc_pkg::G_TIO_PIN];
  assign TIMER_CAPTURE_PIN = pin_val[PG][ppcc_pkg::G_TCAP_PIN];
  assign EXTERNAL_INTERRUPT_INPUT = pin_val[PG][ppcc_pkg::G_INT_PIN];
  assign TWB_SDA_IN = pin_val[PL][ppcc_pkg::L_SDA_PIN];
  assign TWB_SCL_IN = pin_val[PL][ppcc_pkg::L_SCL_PIN];
  // Wake enables live outside; software must clear the Port C enables when absent.
  assign PORT_C_WAKE_LEVELS = pin_val[ppcc_pkg::PORT_C];
  assign PORT_L_WAKE_LEVELS = pin_val[PL];
  assign L_LOW_VOLTAGE_ACTIVE = {3{LOW_VOLTAGE_INPUT_SELECT & TWB_ENABLE}};
  assign SERIAL_SHIFT_CLOCK_ALT_PHASE = cfg_q[PG][ppcc_pkg::G_ALT_PHASE_BIT];

  // ==========================================================================
  // Low-power modes
  assign halt_wr = MEM_WR && port_hit[PG] && reg_ofs == ppcc_pkg::OFS_DATA &&
                   MEM_WDATA[ppcc_pkg::G_HALT_BIT];
  assign idle_wr = MEM_WR && port_hit[PG] && reg_ofs == ppcc_pkg::OFS_DATA &&
                   MEM_WDATA[ppcc_pkg::G_IDLE_BIT];
  assign rc_clock = OSC_RC_SEL && !OSC_CRYSTAL_SEL;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      g7_prev_q <= 1'b0;
    end else begin
      g7_prev_q <= pin_val[ppcc_pkg::PORT_G][ppcc_pkg::G_OSC_PIN];
    end
  end

  assign g7_rise = !OSC_CRYSTAL_SEL && !g7_prev_q &&
                   pin_val[ppcc_pkg::PORT_G][ppcc_pkg::G_OSC_PIN];
  assign wake_any = WAKE_EVENT || g7_rise;

  ppcc_power_ctl u_power (
    .clk(CORE_CLK),
    .rst(RESET),
    .halt_req(halt_wr),
    .idle_req(idle_wr),
    .wake_event(wake_any),
    .idle_exit(IDLE_EXIT),
    .delay_en(cfg_q[PG][ppcc_pkg::G_DELAY_BIT] && rc_clock),
    .halt_mode(HALT_MODE),
    .idle_mode(IDLE_MODE),
    .delay_active(HALT_EXIT_STARTUP_DELAY)
  );

endmodule : ppcc_port_top

`default_nettype wire

// >>> verification/ppcc_port_top_sva.sv
// Concurrent checks on the port control top: reset state, power modes, Port G overrides.
// Assumes it is bound to the top module and sees only that module's ports.
`default_nettype none

module ppcc_port_top_sva (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Register access
  input wire logic [7:0] MEM_ADDR,
  input wire logic MEM_WR,
  input wire logic MEM_RD,
  input wire logic [7:0] MEM_WDATA,
  input wire logic [7:0] MEM_RDATA,
  // Options and sources
  input wire logic OPT_WATCHDOG_DISABLE,
  input wire logic LOW_VOLTAGE_INPUT_SELECT,
  input wire logic OSC_CRYSTAL_SEL,
  input wire logic OSCILLATOR_CLOCK_OUT,
  input wire logic SUPERVISOR_FAULT_OUTPUT,
  input wire logic TWB_ENABLE,
  // Pads
  input wire logic [7:0] PORT_G_OUT,
  input wire logic [7:0] PORT_G_OE_N,
  input wire logic [7:0] PORT_G_PULLUP,
  input wire logic [7:0] PORT_J_OUT,
  input wire logic [7:0] PORT_J_OE_N,
  input wire logic [7:0] PORT_L_IN,
  input wire logic [7:0] PORT_L_WAKE_LEVELS,
  // Status
  input wire logic SERIAL_SHIFT_CLOCK_ALT_PHASE,
  input wire logic [2:0] L_LOW_VOLTAGE_ACTIVE,
  input wire logic HALT_MODE,
  input wire logic IDLE_MODE,
  input wire logic HALT_EXIT_STARTUP_DELAY
);
  localparam logic [7:0] G_BASE = ppcc_pkg::PORT_BASE[ppcc_pkg::PORT_G];
  logic g_data_wr;
  logic g_cfg_wr;
  logic [7:0] run_q;
  logic [7:0] run_d;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  assign g_data_wr = MEM_WR && (MEM_ADDR == G_BASE);
  assign g_cfg_wr = MEM_WR && (MEM_ADDR == G_BASE + 8'h01);
  // Counts how long the current start-up delay has been showing.
  assign run_d = HALT_EXIT_STARTUP_DELAY ? run_q + 8'h01 : 8'h00;
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      run_q <= 8'h00;
    end else begin
      run_q <= run_d;
    end
  end

  a_port_j_reset: assert property (
    $fell(RESET) |-> PORT_J_OE_N == 8'h00 && PORT_J_OUT == 8'hff) else $error("port J not high");
  a_halt_entry: assert property (
    g_data_wr && MEM_WDATA[7] |=> HALT_MODE) else $error("halt not entered");
  a_idle_entry: assert property (
    g_data_wr && MEM_WDATA[6] |=> IDLE_MODE) else $error("idle not entered");
  a_alt_phase: assert property (
    g_cfg_wr |=> SERIAL_SHIFT_CLOCK_ALT_PHASE == $past(MEM_WDATA[6])) else $error("phase bit");
  a_g_read_zero: assert property (
    MEM_RD && MEM_ADDR == G_BASE |=> MEM_RDATA[7:6] == 2'b00) else $error("G data top bits");
  a_g6_input: assert property (
    PORT_G_OE_N[6] && !PORT_G_PULLUP[6]) else $error("G6 not a plain input");
  a_osc_drive: assert property (
    OSC_CRYSTAL_SEL |-> !PORT_G_OE_N[7] && PORT_G_OUT[7] == OSCILLATOR_CLOCK_OUT)
    else $error("G7 not the oscillator output");
  a_g7_input: assert property (
    !OSC_CRYSTAL_SEL |-> PORT_G_OE_N[7] && !PORT_G_PULLUP[7]) else $error("G7 not an input");
  a_wdog_pin: assert property (
    !OPT_WATCHDOG_DISABLE |-> (SUPERVISOR_FAULT_OUTPUT ? PORT_G_OE_N[1] && PORT_G_PULLUP[1]
      : !PORT_G_OE_N[1] && !PORT_G_OUT[1])) else $error("G1 not the watchdog pin");
  a_low_volt: assert property (
    L_LOW_VOLTAGE_ACTIVE == {3{LOW_VOLTAGE_INPUT_SELECT & TWB_ENABLE}})
    else $error("low-voltage select");
  a_wake_sample: assert property (
    !$past(RESET) |-> PORT_L_WAKE_LEVELS == $past(PORT_L_IN)) else $error("L wake levels");
  a_delay_length: assert property (
    $fell(HALT_EXIT_STARTUP_DELAY) |-> run_q == ppcc_pkg::HALT_EXIT_DELAY_CYCLES && $past(HALT_MODE))
    else $error("start-up delay length");
  a_delay_halted: assert property (
    HALT_EXIT_STARTUP_DELAY |-> HALT_MODE) else $error("delay outside halt");
endmodule : ppcc_port_top_sva

`default_nettype wire

// >>> verification/ppcc_board_pads.sv
// Board-side model of one 8-bit pad group: device drive, board drivers or keys, pull-ups.
// Assumes the device pad outputs and board stimulus only change away from clock edges.
`default_nettype none

module ppcc_board_pads (
  // Clock
  input wire logic clk,
  // Device side
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pull_en,
  // Board side
  input wire logic [7:0] board_drv,
  input wire logic [7:0] board_val,
  output logic [7:0] pad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_q = 8'h00;

  // A pin that nobody drives or pulls shows a level that changes every cycle.
  always @(posedge clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad[i] = !pad_oe_n[i] ? pad_out[i] : board_drv[i] ? board_val[i] : pull_en[i] | float_q[i];
    end
  end
endmodule : ppcc_board_pads

`default_nettype wire

// >>> verification/test_ppcc_port_top.sv
// Self-checking bench for the port control top: registers, pin setup, Port G, power, Port L.
// Assumes the package, interface, design and board model are compiled first.
`default_nettype none

module test_ppcc_port_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int G = ppcc_pkg::PORT_G;
  logic clk = 1'b0;
  logic rst, wr, rd, hit, wd_dis, lv_sel, xtal, rc, osc, fault, per_oe, per_out;
  logic twb, sda_lo, scl_lo, sda_in, scl_in, wake, idle_exit, alt, halt, idle, dly;
  logic [7:0] addr, wdata, rdata, b, cwake, lwake;
  logic [4:0] g_in;
  logic [2:0] lva;
  logic [7:0] pin_in [5];
  logic [7:0] pout [5];
  logic [7:0] poe [5];
  logic [7:0] ppu [5];
  logic [7:0] drv [5];
  logic [7:0] val [5];
  int err_total = 0;
  int checks = 0;

  always #20 clk = ~clk;

  ppcc_port_top DUT (
    .CORE_CLK(clk), .RESET(rst), .MEM_ADDR(addr), .MEM_WR(wr), .MEM_RD(rd),
    .MEM_WDATA(wdata), .MEM_RDATA(rdata), .MEM_RD_HIT(hit), .OPT_WATCHDOG_DISABLE(wd_dis),
    .LOW_VOLTAGE_INPUT_SELECT(lv_sel), .OSC_CRYSTAL_SEL(xtal), .OSC_RC_SEL(rc),
    .PORT_C_IN(pin_in[0]), .PORT_C_OUT(pout[0]), .PORT_C_OE_N(poe[0]), .PORT_C_PULLUP(ppu[0]),
    .PORT_F_IN(pin_in[1]), .PORT_F_OUT(pout[1]), .PORT_F_OE_N(poe[1]), .PORT_F_PULLUP(ppu[1]),
    .PORT_G_IN(pin_in[2]), .PORT_G_OUT(pout[2]), .PORT_G_OE_N(poe[2]), .PORT_G_PULLUP(ppu[2]),
    .PORT_J_IN(pin_in[3]), .PORT_J_OUT(pout[3]), .PORT_J_OE_N(poe[3]), .PORT_J_PULLUP(ppu[3]),
    .PORT_L_IN(pin_in[4]), .PORT_L_OUT(pout[4]), .PORT_L_OE_N(poe[4]), .PORT_L_PULLUP(ppu[4]),
    .OSCILLATOR_CLOCK_OUT(osc), .SUPERVISOR_FAULT_OUTPUT(fault),
    .SERIAL_SHIFT_CLOCK_OE(per_oe), .SERIAL_SHIFT_CLOCK_OUT(per_out), .SERIAL_DATA_OE(per_oe),
    .SERIAL_DATA_OUT(per_out), .TIMER_IO_PIN_OE(per_oe), .TIMER_IO_PIN_OUT(per_out),
    .SERIAL_DATA_IN(g_in[4]), .SERIAL_SHIFT_CLOCK_IN(g_in[3]),
    .SERIAL_SHIFT_CLOCK_ALT_PHASE(alt), .TIMER_IO_PIN_IN(g_in[2]), .TIMER_CAPTURE_PIN(g_in[1]),
    .EXTERNAL_INTERRUPT_INPUT(g_in[0]), .TWB_ENABLE(twb), .TWB_SDA_DRIVE_LOW(sda_lo),
    .TWB_SCL_DRIVE_LOW(scl_lo), .TWB_SDA_IN(sda_in), .TWB_SCL_IN(scl_in),
    .L_LOW_VOLTAGE_ACTIVE(lva), .PORT_C_WAKE_LEVELS(cwake), .PORT_L_WAKE_LEVELS(lwake),
    .WAKE_EVENT(wake), .IDLE_EXIT(idle_exit), .HALT_MODE(halt), .IDLE_MODE(idle),
    .HALT_EXIT_STARTUP_DELAY(dly));

  for (genvar p = 0; p < 5; p++) begin : g_board
    ppcc_board_pads u_board (.clk(clk), .pad_out(pout[p]), .pad_oe_n(poe[p]), .pull_en(ppu[p]),
      .board_drv(drv[p]), .board_val(val[p]), .pad(pin_in[p]));
  end

  // ==========================================================================
  // Access tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, exp);
    chk({7'h00, hit}, {7'h00, exp_hit});
  endtask : rd_reg

  task automatic complete_run();
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    complete_run();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    {rst, wr, rd, wd_dis, lv_sel, xtal, rc, osc, fault, per_oe, per_out} = 11'h480;
    {twb, sda_lo, scl_lo, idle_exit, wake} = 5'h00;
    {addr, wdata} = 16'h0000;
    drv = '{default: 8'hff};
    val = '{default: 8'h00};
    cyc(5);
    rst = 1'b0;
    chk(poe[3], 8'h00);
    chk(pout[3], 8'hff);
    for (int p = 0; p < 5; p++) begin
      b = ppcc_pkg::PORT_BASE[p];
      rd_reg(b + 8'h01, (p == 3) ? 8'hff : 8'h00, 1'b1);
      rd_reg(b, (p == 3) ? 8'hff : 8'h00, 1'b1);
    end
    rd_reg(ppcc_pkg::PORT_BASE[G] + 8'h03, 8'h00, 1'b0);
    for (int p = 0; p < 5; p++) begin
      if (p == G) continue;
      b = ppcc_pkg::PORT_BASE[p];
      drv[p] = 8'hf1;
      val[p] = 8'h50;
      wr_reg(b + 8'h01, 8'h0c);
      wr_reg(b, 8'h0a);
      chk({4'h0, poe[p][3:0]}, 8'h03);
      chk({4'h0, ppu[p][3:0]}, 8'h02);
      chk({6'h00, pout[p][3:2]}, 8'h02);
      rd_reg(b + 8'h02, 8'h5a, 1'b1);
      drv[p][1] = 1'b1;
      rd_reg(b + 8'h02, 8'h58, 1'b1);
      if (p == ppcc_pkg::PORT_C) chk(cwake, 8'h58);
      wr_reg(b + 8'h02, 8'hff);
      rd_reg(b + 8'h01, 8'h0c, 1'b1);
    end
    b = ppcc_pkg::PORT_BASE[G];
    for (int k = 0; k < 2; k++) begin
      val[G] = k ? 8'h28 : 8'h45;
      cyc(2);
      chk({3'h0, g_in}, k ? 8'h0c : 8'h13);
    end
    {per_oe, per_out} = 2'b11;
    wr_reg(b + 8'h01, 8'h50);
    chk({7'h00, alt}, 8'h01);
    chk({7'h00, pout[G][4]}, 8'h01);
    per_oe = 1'b0;
    cyc(1);
    chk({7'h00, pout[G][4]}, 8'h00);
    {wd_dis, fault} = 2'b01;
    wr_reg(b + 8'h01, 8'h02);
    wr_reg(b, 8'h02);
    chk({6'h00, poe[G][1], ppu[G][1]}, 8'h03);
    fault = 1'b0;
    cyc(1);
    chk({6'h00, poe[G][1], pout[G][1]}, 8'h00);
    wd_dis = 1'b1;
    cyc(1);
    chk({6'h00, poe[G][1], pout[G][1]}, 8'h01);
    wr_reg(b, 8'h82);
    chk({7'h00, halt}, 8'h01);
    rd_reg(b, 8'h02, 1'b1);
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    cyc(1);
    chk({7'h00, halt}, 8'h00);
    wr_reg(b, 8'h42);
    chk({7'h00, idle}, 8'h01);
    rd_reg(b, 8'h02, 1'b1);
    idle_exit = 1'b1;
    cyc(1);
    idle_exit = 1'b0;
    cyc(1);
    chk({7'h00, idle}, 8'h00);
    val[G] = 8'h00;
    wr_reg(b, 8'h82);
    val[G][7] = 1'b1;
    cyc(3);
    chk({7'h00, halt}, 8'h00);
    rc = 1'b1;
    val[G][7] = 1'b0;
    wr_reg(b + 8'h01, 8'h82);
    wr_reg(b, 8'h82);
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    chk({6'h00, halt, dly}, 8'h03);
    cyc(32);
    chk({6'h00, halt, dly}, 8'h00);
    xtal = 1'b1;
    for (int k = 0; k < 2; k++) begin
      osc = k[0];
      cyc(1);
      chk({6'h00, poe[G][7], pout[G][7]}, {7'h00, k[0]});
    end
    xtal = 1'b0;
    twb = 1'b1;
    for (int k = 0; k < 2; k++) begin
      lv_sel = k[0];
      cyc(1);
      chk({5'h00, lva}, k ? 8'h07 : 8'h00);
    end
    sda_lo = 1'b1;
    drv[4] = 8'hfe;
    val[4] = 8'ha7;
    cyc(2);
    chk({6'h00, poe[4][0], pout[4][0]}, 8'h00);
    chk(lwake, 8'haa);
    chk({6'h00, sda_in, scl_in}, 8'h01);
    {sda_lo, scl_lo} = 2'b01;
    cyc(1);
    chk({6'h00, poe[4][1], pout[4][1]}, 8'h00);
    complete_run();
  end
endmodule : test_ppcc_port_top

bind ppcc_port_top ppcc_port_top_sva u_sva (.*);

`default_nettype wire
